// [hdl/pod_map.vh]
// register offsets, field positions, reset values and timing counts for the port output disable
`ifndef POD_MAP_VH
`define POD_MAP_VH
`define POD_OFF_OUT_CTRL   12'h000
`define POD_OFF_IN_CTRL    12'h004
`define POD_OFF_OUT_STATE  12'h008
`define POD_OFF_PORT_DATA  12'h00c
`define POD_OSF_BIT        15
`define POD_OCE_BIT        9
`define POD_OIE_BIT        8
`define POD_PIE_BIT        8
`define POD_IFLAG_LO       12
`define POD_OUT_CTRL_RST   16'h0000
`define POD_IN_CTRL_RST    16'h0000
`define POD_PORT_HIZ_MASK  16'hfa00
`define POD_LOW_SAMPLES    5'd16
`define POD_DIV_A          8'd8
`define POD_DIV_B          8'd16
`define POD_DIV_C          8'd128
`endif

// [hdl/pod_sync.v]
// two flip-flop synchroniser for one external level
`timescale 1ns/100ps
module pod_sync (
  // clock and reset
  input  wire pclk,
  input  wire presetn,
  // level in and out
  input  wire din,
  output reg  dout
);
  reg meta_r; // first stage, read only by dout

  // idle inputs are high, so both stages reset high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b1;
      dout   <= 1'b1;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule

// [hdl/pod_detect.v]
// request detector for one active-low disable input: falling edge or sixteen low samples
`include "pod_map.vh"
`timescale 1ns/100ps
module pod_detect (
  // clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // synchronised input and mode
  input  wire       lvl,
  input  wire [1:0] mode,
  // sampling tick for the selected divider
  input  wire       tick,
  // accepted request, one cycle
  output reg        req
);
  reg       prev_r; // last synchronised level
  reg [4:0] cnt_r;  // consecutive low samples

  // edge mode or low-run counting
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= 1'b1;
      cnt_r  <= 5'd0;
      req    <= 1'b0;
    end else begin
      prev_r <= lvl;
      req    <= 1'b0;
      if (mode == 2'b00) begin
        cnt_r <= 5'd0;
        if (prev_r && !lvl)
          req <= 1'b1;
      end else if (tick) begin
        // one high sample restarts the run
        if (lvl) begin
          cnt_r <= 5'd0;
        end else if (cnt_r == `POD_LOW_SAMPLES - 5'd1) begin
          req   <= 1'b1;
          cnt_r <= 5'd0;
        end else begin
          cnt_r <= cnt_r + 5'd1;
        end
      end
    end
  end
endmodule

// [hdl/pod_top.v]
// port output disable: input detection, output short compare and APB registers
//
// Chosen here: the APB slave port and the register addresses.
`include "pod_map.vh"
`timescale 1ns/100ps
module pod_top #(
  parameter NIN   = 4, // external disable inputs
  parameter NPAIR = 3  // compared complementary pairs
) (
  // clock and power-on reset
  input  wire              pclk,
  input  wire              presetn,
  // apb slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  // external disable inputs, active low
  input  wire [NIN-1:0]    ext_disable_input_n,
  // timer output levels: pair k is pair_out_a[k] and pair_out_b[k]
  input  wire [NPAIR-1:0]  pair_out_a,
  input  wire [NPAIR-1:0]  pair_out_b,
  // pin control and interrupt requests
  output reg               outputs_hiz,
  output reg               short_irq,
  output reg               input_irq
);
  // register state
  reg              osf_r;      // output short flag
  reg              oce_r;      // output compare enable
  reg              oie_r;      // short interrupt enable
  reg              osf_seen_r; // flag read as 1, clear armed
  reg [NIN-1:0]    iflag_r;    // input request flags
  reg [NIN-1:0]    iflag_seen_r; // flags read as 1
  reg              pie_r;      // input interrupt enable
  reg [2*NIN-1:0]  imode_r;    // input detect mode fields
  reg [15:0]       port_data_r; // port data register image
  reg [7:0]        pre_r;      // sampling prescaler
  reg [7:0]        pre_last_r; // previous prescaler value

  // bus decode
  wire acc     = psel && penable;
  wire wr      = acc && pwrite;
  wire rd      = acc && !pwrite;
  wire a_oc    = (paddr == `POD_OFF_OUT_CTRL);
  wire a_ic    = (paddr == `POD_OFF_IN_CTRL);
  wire a_st    = (paddr == `POD_OFF_OUT_STATE);
  wire a_pd    = (paddr == `POD_OFF_PORT_DATA);
  wire mapped  = a_oc || a_ic || a_st || a_pd;

  // sampling ticks: divider wraps mark each phi/n sample point
  wire tick8   = (pre_r[2:0] == 3'd7);
  wire tick16  = (pre_r[3:0] == 4'd15);
  wire tick128 = (pre_r[6:0] == 7'd127);

  // synchronised inputs and accepted requests
  wire [NIN-1:0] lvl_s;
  wire [NIN-1:0] ireq;

  // short compare
  reg  [NPAIR-1:0] pair_low;
  wire             any_short = |pair_low;
  wire             oce_set   = wr && a_oc && pwdata[`POD_OCE_BIT];
  wire             oce_eff   = oce_r || oce_set;

  always @* begin : cmp
    integer k;
    pair_low = {NPAIR{1'b0}};
    for (k = 0; k < NPAIR; k = k + 1)
      pair_low[k] = !pair_out_a[k] && !pair_out_b[k];
  end

  genvar g;
  generate
    for (g = 0; g < NIN; g = g + 1) begin : ch
      wire [1:0] m = imode_r[2*g+1:2*g];
      wire tk = (m == 2'b01) ? tick8 : (m == 2'b10) ? tick16 : tick128;
      pod_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (ext_disable_input_n[g]),
        .dout    (lvl_s[g])
      );
      pod_detect u_det (
        .pclk    (pclk),
        .presetn (presetn),
        .lvl     (lvl_s[g]),
        .mode    (m),
        .tick    (tk),
        .req     (ireq[g])
      );
    end
  endgenerate

  // free-running prescaler for the sampling clocks
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r      <= 8'h00;
      pre_last_r <= 8'h00;
    end else begin
      pre_r      <= pre_r + 8'h01;
      pre_last_r <= pre_r;
    end
  end

  // output short control register; presetn is the power-on reset
  // reset only on power-on
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osf_r      <= 1'b0;
      oce_r      <= 1'b0;
      oie_r      <= 1'b0;
      osf_seen_r <= 1'b0;
    end else begin
      // arm the clear when software sees the flag at 1
      if (rd && a_oc && osf_r)
        osf_seen_r <= 1'b1;
      if (wr && a_oc) begin
        oce_r <= pwdata[`POD_OCE_BIT];
        oie_r <= pwdata[`POD_OIE_BIT];
        // write 0 after read 1 clears, write 1 ignored
        if (!pwdata[`POD_OSF_BIT] && osf_seen_r) begin
          osf_r      <= 1'b0;
          osf_seen_r <= 1'b0;
        end
      end
      // set wins over a clear in the same cycle
      // compare enable write sees a low pair at once
      if (oce_eff && any_short)
        osf_r <= 1'b1;
    end
  end

  // input control register and request flags
  always @(posedge pclk or negedge presetn) begin : icr
    integer i;
    if (!presetn) begin
      iflag_r      <= {NIN{1'b0}};
      iflag_seen_r <= {NIN{1'b0}};
      pie_r        <= 1'b0;
      imode_r      <= {2*NIN{1'b0}};
    end else begin
      if (wr && a_ic) begin
        pie_r   <= pwdata[`POD_PIE_BIT];
        imode_r <= pwdata[2*NIN-1:0];
      end
      for (i = 0; i < NIN; i = i + 1) begin
        if (rd && a_ic && iflag_r[i])
          iflag_seen_r[i] <= 1'b1;
        if (wr && a_ic && !pwdata[`POD_IFLAG_LO+i] && iflag_seen_r[i]) begin
          iflag_r[i]      <= 1'b0;
          iflag_seen_r[i] <= 1'b0;
        end
        // accepted request sets its flag, set wins
        if (ireq[i])
          iflag_r[i] <= 1'b1;
      end
    end
  end

  // short hiz condition from flag and both enables
  // needs compare and interrupt enable
  wire short_hiz = osf_r && oce_r && oie_r;
  // immediate short term so the pins float from the same edge that sets the flag
  wire short_now = oce_eff && any_short && (oie_r || (wr && a_oc && pwdata[`POD_OIE_BIT]));

  // port data register image; short hiz forces the documented bits high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_data_r <= 16'h0000;
    end else begin
      if (wr && a_pd)
        port_data_r <= pwdata[15:0];
      // short hiz sets port data bits
      if (short_hiz || short_now)
        port_data_r <= port_data_r | `POD_PORT_HIZ_MASK;
    end
  end

  // pin control and interrupt outputs, all registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      outputs_hiz <= 1'b0;
      short_irq   <= 1'b0;
      input_irq   <= 1'b0;
    end else begin
      // input hiz holds while any flag is set
      // short hiz ends once compare off or flag clear
      outputs_hiz <= (|iflag_r) || (|ireq) || short_hiz || short_now;
      short_irq   <= short_hiz || short_now;
      input_irq   <= pie_r && ((|iflag_r) || (|ireq));
    end
  end

  // apb read data, ready and error; one wait-free access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        if (a_oc)
          prdata <= {16'h0000, osf_r, 5'h00, oce_r, oie_r, 8'h00};
        else if (a_ic)
          prdata <= {16'h0000, iflag_r, 3'h0, pie_r, imode_r};
        else if (a_st)
          prdata <= {27'h0, pair_low, short_hiz, (|iflag_r)};
        else if (a_pd)
          prdata <= {16'h0000, port_data_r};
      end
    end
  end
endmodule

// [tb/pod_pins.sv]
// far side model: disable input drivers and timer output pairs
`timescale 1ns/100ps
module pod_pins (
  // commands from the bench
  input  logic [3:0] dis_req,
  input  logic [2:0] short_req,
  input  logic       all_high,
  // pins toward the block
  output logic [3:0] ext_n,
  output logic [2:0] pair_a,
  output logic [2:0] pair_b
);
  assign ext_n = ~dis_req;
  assign pair_a = ~short_req | {3{all_high}};
  // normally complementary, a high and b low
  assign pair_b = {3{all_high}};
endmodule

// [tb/pod_top_chk.sv]
// checker on the port output disable top ports
`timescale 1ns/100ps
`include "pod_map.vh"
module pod_top_chk #(
  parameter NIN   = 4,
  parameter NPAIR = 3
) (
  // clock and reset
  input logic             pclk,
  input logic             presetn,
  // apb
  input logic             psel,
  input logic             penable,
  input logic             pwrite,
  input logic [11:0]      paddr,
  input logic [31:0]      pwdata,
  input logic [31:0]      prdata,
  input logic             pready,
  input logic             pslverr,
  // pins and requests
  input logic [NIN-1:0]   ext_disable_input_n,
  input logic [NPAIR-1:0] pair_out_a,
  input logic [NPAIR-1:0] pair_out_b,
  input logic             outputs_hiz,
  input logic             short_irq,
  input logic             input_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow copies of control bits, taken at the write edge
  logic           oce_r, oie_r, pie_r;
  logic [7:0]     mode_r;
  logic [NIN-1:0] ext_q;
  logic [NIN-1:0] edge_m;
  wire acc = psel && penable && pready;
  wire wr0 = acc && pwrite && paddr == `POD_OFF_OUT_CTRL;
  wire wr1 = acc && pwrite && paddr == `POD_OFF_IN_CTRL;
  wire rd0 = acc && !pwrite && paddr == `POD_OFF_OUT_CTRL;
  // inputs in falling edge mode
  always_comb
    for (int i = 0; i < NIN; i++)
      edge_m[i] = mode_r[2*i +: 2] == 2'b00;
  // shadow registers; inputs idle high after reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {oce_r, oie_r, pie_r, mode_r} <= '0;
      ext_q <= '1;
    end else begin
      ext_q <= ext_disable_input_n;
      if (wr0) {oce_r, oie_r} <= pwdata[9:8];
      if (wr1) {pie_r, mode_r} <= pwdata[8:0];
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_short;
    oce_r && oie_r && |(~pair_out_a & ~pair_out_b) && !wr0;
  endsequence
  short_hiz_a: assert property (s_short |=> short_irq && outputs_hiz)
    else $error("short pair without hiz and irq");
  irq_gate_a: assert property (!oie_r && !wr0 |=> !short_irq)
    else $error("short irq while disabled");
  input_gate_a: assert property (!pie_r && !wr1 |=> !input_irq)
    else $error("input irq while disabled");
  rsvd_zero_a: assert property (rd0 |-> prdata[31:16] == 0 && prdata[14:10] == 0
    && prdata[7:0] == 0) else $error("reserved bits not zero");
  ctrl_read_a: assert property (rd0 |-> prdata[9:8] == {oce_r, oie_r})
    else $error("enable bits read wrong");
  apb_ready_a: assert property (s_setup |=> pready)
    else $error("no ready in access cycle");
  unmapped_err_a: assert property (psel && !penable && paddr > `POD_OFF_PORT_DATA |=> pslverr)
    else $error("no error on unmapped address");
  edge_hiz_a: assert property (|(ext_q & ~ext_disable_input_n & edge_m)
    |-> ##[1:8] outputs_hiz) else $error("falling edge gave no hiz");
endmodule
bind pod_top pod_top_chk #(.NIN(NIN), .NPAIR(NPAIR)) pod_top_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ext_disable_input_n(ext_disable_input_n), .pair_out_a(pair_out_a),
  .pair_out_b(pair_out_b), .outputs_hiz(outputs_hiz), .short_irq(short_irq),
  .input_irq(input_irq));

// [tb/port_output_disable_test.sv]
// self-checking bench for the port output disable block
`timescale 1ns/100ps
`include "pod_map.vh"
module port_output_disable_test;
  localparam [11:0] OC = `POD_OFF_OUT_CTRL;
  localparam [11:0] IC = `POD_OFF_IN_CTRL;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, ctl;
  wire  [31:0] prdata;
  wire         pready, pslverr, hiz, sirq, iirq;
  wire  [3:0]  ext_n;
  wire  [2:0]  pa, pb;
  logic [3:0]  dis_req = 0;
  logic [2:0]  short_req = 0;
  logic        all_high = 0;
  logic [31:0] exp_q[$], msk_q[$];
  int          fails = 0, n_checks = 0, seed = 32'h48cf, i, k, m, d;
  always #2.5 pclk = ~pclk;
  pod_top pod_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_disable_input_n(ext_n), .pair_out_a(pa), .pair_out_b(pb),
    .outputs_hiz(hiz), .short_irq(sirq), .input_irq(iirq));
  pod_pins pod_pins_inst (.dis_req(dis_req), .short_req(short_req), .all_high(all_high),
    .ext_n(ext_n), .pair_a(pa), .pair_b(pb));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one apb transfer; held until ready is seen, then released
  task apb(input logic [11:0] a, input logic w, input logic [31:0] dt);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, dt};
    @(posedge pclk);
    penable <= 1;
    // hold the request until ready is seen high at a rising edge
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 16);
    if (n >= 16) begin
      fails++;
      tally_and_finish;
    end
    {psel, penable} <= 2'b00;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] dt);
    apb(a, 1'b1, dt);
  endtask
  // note the expected word, then read
  task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] mk);
    exp_q.push_back(e & mk);
    msk_q.push_back(mk);
    apb(a, 1'b0, 32'h0);
  endtask
  // wait, then compare {hiz, short irq, input irq} on a settled edge
  task pin(input int c, input logic [2:0] e);
    repeat (c) @(posedge pclk);
    @(negedge pclk);
    chk({29'h0, hiz, sirq, iirq}, {29'h0, e});
  endtask
  // read monitor: oldest note against the data bus
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk(prdata & msk_q.pop_front(), exp_q.pop_front());
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    rd(OC, 32'h0, '1);
    rd(IC, 32'h0, '1);
    wr(OC, 32'hffff_80ff);
    rd(OC, 32'h0, '1);
    rd(12'h010, 32'h0, '1);
    // short on each pair; the last one with its interrupt off
    for (k = 0; k < 3; k++) begin
      ctl = (k == 2) ? 32'h0200 : 32'h0300;
      @(posedge pclk);
      short_req <= 3'b001 << k;
      pin(4, 3'b000);
      // pins drive as outputs before compare enable
      wr(OC, ctl);
      pin(2, (k == 2) ? 3'b000 : 3'b110);
      wr(OC, ctl);
      rd(OC, ctl | 32'h8000, '1);
      if (k < 2) rd(`POD_OFF_PORT_DATA, 32'hfa00, `POD_PORT_HIZ_MASK);
      @(posedge pclk);
      all_high <= 1;
      short_req <= 0;
      wr(OC, 32'h8000 | (ctl & 32'h0100));
      wr(OC, ctl & 32'h0100);
      pin(2, 3'b000);
      rd(OC, ctl & 32'h0100, '1);
      @(posedge pclk);
      all_high <= 0;
    end
    // falling edge on each input
    wr(IC, 32'h0100);
    for (i = 0; i < 4; i++) begin
      @(posedge pclk);
      dis_req <= 4'b0001 << i;
      pin(8, 3'b101);
      @(posedge pclk);
      dis_req <= 0;
      rd(IC, 32'h0100 | (32'h1000 << i), '1);
      wr(IC, 32'h0100);
      pin(2, 3'b000);
    end
    // sixteen low samples, a high sample restarts the count
    for (m = 1; m < 4; m++) begin
      i = $unsigned($random(seed)) % 4;
      d = (m == 1) ? 8 : (m == 2) ? 16 : 128;
      wr(IC, 32'h0100 | (m << (2 * i)));
      @(posedge pclk);
      dis_req <= 4'b0001 << i;
      pin(14 * d, 3'b000);
      @(posedge pclk);
      dis_req <= 0;
      pin(2 * d, 3'b000);
      @(posedge pclk);
      dis_req <= 4'b0001 << i;
      pin(14 * d, 3'b000);
      pin(4 * d, 3'b101);
      @(posedge pclk);
      dis_req <= 0;
      rd(IC, 32'h0100 | (32'h1000 << i) | (m << (2 * i)), '1);
      wr(IC, 32'h0100);
      pin(2, 3'b000);
    end
    tally_and_finish;
  end
endmodule
